// file: swg_pkg.sv
// Shared constants and state types for the single-wire gauge link.
// Function
// [R1] Host arms ship: mode bit, then 0xA9 to 0x00.
// [R2] Ship entered after armed line low 16 s.
// [R3] Short transients never restart the ship arming.
// [R4] Ship halts everything; line high or POR resumes.
// [R5] Glitch leaves ship; rearm needs new ship command.
// [R6] EEPROM writes need unlock: 0xDD to 0x6E.
// [R7] Host programs 0x76-0x7F one byte per sequence.
// [R8] After command, store or send addressed byte.
// [R9] All bytes travel least significant bit first.
// [R10] Bit rate never above 5 Kbits/s.
// [R11] Low for break time resets receive state.
// [R12] Host breaks first and after missing responses.
// [R13] Host holds breaks twice the minimum time.
// [R14] Line high for recovery before next command.
// [R15] Bit frame: low, data, then high to cycle.
// [R16] Idle gaps between bits never time out.
// [R17] Read data starts one response delay later.
// [R18] Host precedes transfers with a break.
// [R19] Command: flag bit 7, address bits 6-0.
// [R20] Open drain line: pull low or release only.
// [R21] Flag 1 writes next byte, 0 reads register.
// [R22] Host reads pairs high, low, high within 0.8 s; the host here reads one byte per started sequence.
// [R23] Receiver samples between one and zero low times.
// [R24] Break mid-byte discards partial byte.
package swg_pkg;
  localparam int CLK_MHZ = 20;
  localparam int BRK_US = 190;
  localparam int BR_US = 40;
  localparam int HOST_REC_US = 60;
  localparam int HW1_US = 50;
  localparam int HW0_US = 100;
  localparam int HCYC_US = 200;
  localparam int DW1_US = 40;
  localparam int DW0_US = 100;
  localparam int DCYC_US = 200;
  localparam int RESP_US = 200;
  localparam int HOST_TO_US = 300;
  localparam int DSAMPLE_US = 75;
  localparam int HSAMPLE_US = 70;
  localparam int SHIP_S = 16;
  localparam int GLITCH_US = 1000;
  localparam logic [12:0] D_BRK_CYC = 13'(BRK_US * CLK_MHZ);
  localparam logic [12:0] D_BR_CYC = 13'(BR_US * CLK_MHZ);
  localparam logic [12:0] D_SAMPLE_CYC = 13'(DSAMPLE_US * CLK_MHZ);
  localparam logic [12:0] D_RESP_CYC = 13'(RESP_US * CLK_MHZ);
  localparam logic [12:0] D_DW1_CYC = 13'(DW1_US * CLK_MHZ);
  localparam logic [12:0] D_DW0_CYC = 13'(DW0_US * CLK_MHZ);
  localparam logic [12:0] D_CYC_CYC = 13'(DCYC_US * CLK_MHZ);
  localparam logic [15:0] H_REC_CYC = 16'(HOST_REC_US * CLK_MHZ);
  localparam logic [15:0] H_HW1_CYC = 16'(HW1_US * CLK_MHZ);
  localparam logic [15:0] H_HW0_CYC = 16'(HW0_US * CLK_MHZ);
  localparam logic [15:0] H_CYC_CYC = 16'(HCYC_US * CLK_MHZ);
  localparam logic [15:0] H_SAMPLE_CYC = 16'(HSAMPLE_US * CLK_MHZ);
  localparam int HOST_BRK_CYC = 2 * BRK_US * CLK_MHZ;
  localparam int HOST_TO_CYC = HOST_TO_US * CLK_MHZ;
  localparam int SHIP_CYC = SHIP_S * CLK_MHZ * 1000000;
  localparam int GLITCH_CYC = GLITCH_US * CLK_MHZ;
  localparam int CMD_WR_BIT = 7;
  localparam logic [6:0] CTRL_ADDR = 7'h00;
  localparam logic [7:0] SHIP_CMD = 8'hA9;
  localparam logic [6:0] MODE_ADDR = 7'h01;
  localparam int MODE_SHIP_BIT = 0;
  localparam logic [6:0] UNLOCK_ADDR = 7'h6E;
  localparam logic [7:0] UNLOCK_KEY = 8'hDD;
  localparam logic [6:0] EE_FIRST = 7'h76;
  localparam logic [6:0] EE_LAST = 7'h7F;
  localparam logic [7:0] H_CTRL_OFF = 8'h00;
  localparam logic [7:0] H_CMD_OFF = 8'h04;
  localparam logic [7:0] H_STAT_OFF = 8'h08;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_BRK_BIT = 1;

  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_LOW = 3'b001, D_WAITHI = 3'b010,
    D_RECOV = 3'b011, D_RESP = 3'b100, D_TX = 3'b101
  } swg_dst_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_BRK = 3'b001, H_REC = 3'b010, H_TX = 3'b011,
    H_RESP = 3'b100, H_RXLOW = 3'b101, H_RXWAIT = 3'b110
  } swg_hst_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    swg_dst_t st;
    logic [12:0] cnt;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic isData;
    logic respPend;
    logic [7:0] cmd;
    logic oeN;
    logic [127:0][7:0] regs;
    logic unlocked;
    logic armed;
    logic ship;
    logic [28:0] shipCnt;
    logic [14:0] hiCnt;
    logic por1;
    logic por2;
    logic porPrev;
  } swg_dev_state_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    swg_hst_t st;
    logic [15:0] cnt;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic txData;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic timeout;
    logic oeN;
    logic dpValid;
    logic dpWrite;
    logic [7:0] dpAddr;
    logic [31:0] hrdata;
  } swg_host_state_t;

  localparam swg_dev_state_t DEV_RST = '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, oeN: 1'b1, st: D_IDLE, default: '0};
  localparam swg_host_state_t HOST_RST = '{sync1: 1'b1, sync2: 1'b1, prev: 1'b1, oeN: 1'b1, st: H_IDLE,
                                           default: '0};
endpackage : swg_pkg

// file: swg_link_if.sv
// Open-drain single-wire link joining the gauge device and the host.
`timescale 1ns/1ps
interface swg_link_if;
  logic devOut;
  logic devOeN;
  logic hostOut;
  logic hostOeN;
  logic lineIn;

  // The external pull-up gives a high level unless one end pulls low.
  assign lineIn = (devOeN | devOut) & (hostOeN | hostOut);

  modport dev(input lineIn, output devOut, output devOeN);
  modport host(input lineIn, output hostOut, output hostOeN);
endinterface : swg_link_if

// file: swg_device.sv
// Gauge device end of the single-wire link with its register file and ship mode.
`timescale 1ns/1ps
module swg_device #(
  parameter int SHIP_LOW_CYC = swg_pkg::SHIP_CYC,
  parameter int SHIP_GLITCH_CYC = swg_pkg::GLITCH_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  swg_link_if.dev link,
  input wire logic batteryAbovePor,
  input wire logic userWrEn,
  input wire logic [6:0] userAddr,
  input wire logic [7:0] userData,
  output logic shipMode,
  output logic shipArmed,
  output logic eepromUnlocked
);
  swg_pkg::swg_dev_state_t s;
  swg_pkg::swg_dev_state_t n;
  logic line;
  logic fall;

  assign line = s.sync2;
  assign fall = s.prev & ~s.sync2;

  // Closes a received bit once the line is high again; acts on a whole byte.
  function automatic swg_pkg::swg_dev_state_t finishBit(input swg_pkg::swg_dev_state_t x);
    swg_pkg::swg_dev_state_t y;
    logic [6:0] a;
    y = x;
    a = x.cmd[6:0];
    if (x.bitCnt == 4'h8) begin
      y.bitCnt = 4'h0;
      if (!x.isData) begin
        y.cmd = x.shift; // [R19]
        if (x.shift[swg_pkg::CMD_WR_BIT]) begin
          y.isData = 1'b1; // [R21]
        end else begin
          y.respPend = 1'b1; // [R8] [R21]
        end
      end else begin
        y.isData = 1'b0;
        if (a == swg_pkg::CTRL_ADDR) begin
          if (x.shift == swg_pkg::SHIP_CMD && x.regs[swg_pkg::MODE_ADDR][swg_pkg::MODE_SHIP_BIT]) begin
            y.armed = 1'b1; // [R1]
          end
        end else if (a == swg_pkg::UNLOCK_ADDR) begin
          // Any other value locks programming again.
          y.unlocked = (x.shift == swg_pkg::UNLOCK_KEY); // [R6]
        end else if (a >= swg_pkg::EE_FIRST && a <= swg_pkg::EE_LAST) begin
          if (x.unlocked) begin
            y.regs[a] = x.shift; // [R6] [R7]
          end
        end else begin
          y.regs[a] = x.shift; // [R8]
        end
      end
    end
    y.cnt = 13'h0000;
    y.st = y.respPend ? swg_pkg::D_RESP : swg_pkg::D_IDLE;
    y.respPend = 1'b0;
    return y;
  endfunction : finishBit

  always_comb begin
    n = s;
    n.sync1 = link.lineIn;
    n.sync2 = s.sync1;
    n.prev = s.sync2;
    n.por1 = batteryAbovePor;
    n.por2 = s.por1;
    n.porPrev = s.por2;
    if (userWrEn) begin
      n.regs[userAddr] = userData;
    end
    if (!line) begin
      n.hiCnt = 15'h0000;
    end else if (s.hiCnt != 15'h7FFF) begin
      n.hiCnt = s.hiCnt + 15'h0001;
    end

    unique case (s.st)
      swg_pkg::D_IDLE: begin
        // No timeout here: the host may idle as long as it likes between bits.
        if (fall) begin // [R16]
          n.st = swg_pkg::D_LOW;
          n.cnt = 13'h0000;
        end
      end
      swg_pkg::D_LOW: begin
        n.cnt = s.cnt + 13'h0001;
        if (s.cnt == swg_pkg::D_SAMPLE_CYC) begin
          n.shift = {line, s.shift[7:1]}; // [R23] [R9]
          n.bitCnt = s.bitCnt + 4'h1;
          if (line) begin
            n = finishBit(n);
          end else begin
            n.st = swg_pkg::D_WAITHI;
          end
        end
      end
      swg_pkg::D_WAITHI: begin
        if (line) begin
          if (s.cnt >= swg_pkg::D_BRK_CYC) begin
            // A break drops any partial byte and pending command.
            n.bitCnt = 4'h0; // [R11] [R24]
            n.isData = 1'b0;
            n.respPend = 1'b0;
            n.st = swg_pkg::D_RECOV;
            n.cnt = 13'h0000;
          end else begin
            n = finishBit(n);
          end
        end else if (s.cnt != 13'h1FFF) begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      swg_pkg::D_RECOV: begin
        if (!line) begin
          n.cnt = 13'h0000;
        end else if (s.cnt == swg_pkg::D_BR_CYC - 13'h0001) begin
          n.st = swg_pkg::D_IDLE; // [R14]
          n.cnt = 13'h0000;
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      swg_pkg::D_RESP: begin
        if (s.cnt == swg_pkg::D_RESP_CYC - 13'h0001) begin
          n.st = swg_pkg::D_TX; // [R17]
          n.cnt = 13'h0000;
          n.bitCnt = 4'h0;
          n.shift = s.regs[s.cmd[6:0]]; // [R8]
        end else begin
          n.cnt = s.cnt + 13'h0001;
        end
      end
      swg_pkg::D_TX: begin
        // Breaks are not watched while sending, so a short one may be missed.
        if (s.cnt == swg_pkg::D_CYC_CYC - 13'h0001) begin
          n.cnt = 13'h0000;
          n.shift = {1'b0, s.shift[7:1]}; // [R9]
          if (s.bitCnt == 4'h7) begin
            n.bitCnt = 4'h0;
            n.st = swg_pkg::D_IDLE;
          end else begin
            n.bitCnt = s.bitCnt + 4'h1;
          end
        end else begin
          n.cnt = s.cnt + 13'h0001; // [R10]
        end
      end
      default: begin
        n.st = swg_pkg::D_IDLE;
        n.cnt = 13'h0000;
      end
    endcase

    if (s.ship) begin
      // Everything stands still; only a high line or a fresh power-on wakes it.
      n = s; // [R4]
      n.sync1 = link.lineIn;
      n.sync2 = s.sync1;
      n.prev = s.sync2;
      n.por1 = batteryAbovePor;
      n.por2 = s.por1;
      n.porPrev = s.por2;
      n.hiCnt = 15'h0000;
      n.st = swg_pkg::D_IDLE;
      n.bitCnt = 4'h0;
      n.isData = 1'b0;
      if (line || (s.por2 && !s.porPrev)) begin
        n.ship = 1'b0; // [R4] [R5]
      end
    end else if (s.armed) begin
      // Only a long high level restarts the low timer, not a brief spike.
      if (s.hiCnt >= 15'(SHIP_GLITCH_CYC)) begin
        n.shipCnt = 29'h00000000; // [R3]
      end else if (s.shipCnt == 29'(SHIP_LOW_CYC - 1)) begin
        n.ship = 1'b1; // [R2]
        n.armed = 1'b0; // [R5]
        n.shipCnt = 29'h00000000;
      end else begin
        n.shipCnt = s.shipCnt + 29'h00000001; // [R2]
      end
    end else begin
      n.shipCnt = 29'h00000000;
    end

    // Pull low for the lead, hold low for a zero, then release. [R15]
    n.oeN = !(n.st == swg_pkg::D_TX && (n.cnt < swg_pkg::D_DW1_CYC ||
             (n.cnt < swg_pkg::D_DW0_CYC && !n.shift[0]))); // [R20]
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= swg_pkg::DEV_RST;
    end else begin
      s <= n;
    end
  end

  assign link.devOut = 1'b0; // [R20]
  assign link.devOeN = s.oeN;
  assign shipMode = s.ship;
  assign shipArmed = s.armed;
  assign eepromUnlocked = s.unlocked;
endmodule : swg_device

// file: swg_host.sv
// Host end of the single-wire link, driven by software over AHB-Lite.
`timescale 1ns/1ps
module swg_host #(
  parameter int BRK_HOLD_CYC = swg_pkg::HOST_BRK_CYC,
  parameter int RESP_TO_CYC = swg_pkg::HOST_TO_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  swg_link_if.host link,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  swg_pkg::swg_host_state_t s;
  swg_pkg::swg_host_state_t n;
  logic line;
  logic fall;
  logic busy;

  assign line = s.sync2;
  assign fall = s.prev & ~s.sync2;
  assign busy = (s.st != swg_pkg::H_IDLE);

  always_comb begin
    n = s;
    n.sync1 = link.lineIn;
    n.sync2 = s.sync1;
    n.prev = s.sync2;
    n.dpValid = 1'b0;
    // Only whole-word single transfers are used, so hsize is not decoded.
    if (hsel && hready && htrans[1]) begin
      n.dpValid = 1'b1;
      n.dpWrite = hwrite;
      n.dpAddr = haddr[7:0];
      n.hrdata = 32'h00000000;
      if (!hwrite && haddr[7:0] == swg_pkg::H_CMD_OFF) begin
        n.hrdata = {16'h0000, s.wdata, s.cmd};
      end else if (!hwrite && haddr[7:0] == swg_pkg::H_STAT_OFF) begin
        n.hrdata = {16'h0000, s.rdata, 6'h00, s.timeout, busy};
      end
    end
    if (s.dpValid && s.dpWrite && !busy) begin
      if (s.dpAddr == swg_pkg::H_CMD_OFF) begin
        n.cmd = hwdata[7:0];
        n.wdata = hwdata[15:8];
      end else if (s.dpAddr == swg_pkg::H_CTRL_OFF && hwdata[swg_pkg::CTRL_START_BIT]) begin
        n.timeout = 1'b0;
        n.bitCnt = 4'h0;
        n.cnt = 16'h0000;
        n.txData = 1'b0;
        n.shift = s.cmd;
        n.st = hwdata[swg_pkg::CTRL_BRK_BIT] ? swg_pkg::H_BRK : swg_pkg::H_TX; // [R12] [R18]
      end
    end

    unique case (s.st)
      swg_pkg::H_IDLE: begin
      end
      swg_pkg::H_BRK: begin
        if (s.cnt == 16'(BRK_HOLD_CYC - 1)) begin
          n.st = swg_pkg::H_REC; // [R13]
          n.cnt = 16'h0000;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      swg_pkg::H_REC: begin
        if (s.cnt == swg_pkg::H_REC_CYC - 16'h0001) begin
          n.st = swg_pkg::H_TX; // [R14]
          n.cnt = 16'h0000;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      swg_pkg::H_TX: begin
        if (s.cnt == swg_pkg::H_CYC_CYC - 16'h0001) begin
          n.cnt = 16'h0000; // [R10]
          n.shift = {1'b0, s.shift[7:1]}; // [R9]
          n.bitCnt = s.bitCnt + 4'h1;
          if (s.bitCnt == 4'h7) begin
            n.bitCnt = 4'h0;
            if (s.cmd[swg_pkg::CMD_WR_BIT] && !s.txData) begin
              n.txData = 1'b1; // [R21]
              n.shift = s.wdata;
            end else begin
              n.st = s.cmd[swg_pkg::CMD_WR_BIT] ? swg_pkg::H_IDLE : swg_pkg::H_RESP;
            end
          end
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      swg_pkg::H_RESP, swg_pkg::H_RXWAIT: begin
        if (s.st == swg_pkg::H_RXWAIT && line && s.bitCnt == 4'h8) begin
          n.rdata = s.shift;
          n.bitCnt = 4'h0;
          n.st = swg_pkg::H_IDLE;
        end else if (fall) begin
          n.st = swg_pkg::H_RXLOW;
          n.cnt = 16'h0000;
        end else if (s.cnt == 16'(RESP_TO_CYC - 1)) begin
          // Software must send a break before retrying.
          n.timeout = 1'b1; // [R12]
          n.st = swg_pkg::H_IDLE;
        end else begin
          n.cnt = s.cnt + 16'h0001;
        end
      end
      swg_pkg::H_RXLOW: begin
        n.cnt = s.cnt + 16'h0001;
        if (s.cnt == swg_pkg::H_SAMPLE_CYC) begin
          n.shift = {line, s.shift[7:1]}; // [R9] [R15]
          n.bitCnt = s.bitCnt + 4'h1;
          n.st = swg_pkg::H_RXWAIT;
          n.cnt = 16'h0000;
        end
      end
      default: begin
        n.st = swg_pkg::H_IDLE;
      end
    endcase

    n.oeN = !(n.st == swg_pkg::H_BRK || (n.st == swg_pkg::H_TX && (n.cnt < swg_pkg::H_HW1_CYC ||
             (n.cnt < swg_pkg::H_HW0_CYC && !n.shift[0])))); // [R15] [R20]
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s <= swg_pkg::HOST_RST;
    end else begin
      s <= n;
    end
  end

  assign link.hostOut = 1'b0;
  assign link.hostOeN = s.oeN;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.hrdata;
endmodule : swg_host

// file: swg_link_properties.sv
// Line checks between the host end and the device end of the single-wire link.
`timescale 1ns/1ps
module swg_link_properties (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic devOut,
  input wire logic devOeN,
  input wire logic hostOut,
  input wire logic hostOeN,
  input wire logic lineIn
);
  logic [15:0] devLow;
  logic [15:0] hostLow;
  logic [15:0] devGap;
  logic [15:0] hostGap;
  logic [15:0] sinceHost;
  logic [9:0] recLeft;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  function automatic logic [15:0] sat(input logic [15:0] v);
    return (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction : sat

  // The counters saturate, so a pulse or gap past 65535 cycles reads as 65535 instead of wrapping below a bound.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      devLow <= 16'h0000;
      hostLow <= 16'h0000;
      devGap <= 16'hFFFF;
      hostGap <= 16'hFFFF;
      sinceHost <= 16'hFFFF;
      recLeft <= 10'h000;
    end else begin
      devLow <= devOeN ? 16'h0000 : sat(devLow);
      hostLow <= hostOeN ? 16'h0000 : sat(hostLow);
      devGap <= $fell(devOeN) ? 16'h0001 : sat(devGap);
      hostGap <= $fell(hostOeN) ? 16'h0001 : sat(hostGap);
      sinceHost <= $rose(hostOeN) ? 16'h0001 : sat(sinceHost);
      // Counts down the recovery cycles that follow a break, so a long hold needs no long delay.
      if ($rose(hostOeN) && hostLow >= 16'h0ED8) begin
        recLeft <= 10'h31F;
      end else if (recLeft != 10'h000) begin
        recLeft <= recLeft - 10'h001;
      end
    end
  end

  sequence s_dev_start;
    $fell(devOeN);
  endsequence
  sequence s_break_end;
    $rose(hostOeN) && hostLow >= 16'h0ED8;
  endsequence

  property p_dev_pull;
    !devOeN |-> !devOut && !lineIn;
  endproperty
  property p_host_pull;
    !hostOeN |-> !hostOut && !lineIn;
  endproperty
  property p_dev_low;
    $rose(devOeN) |-> devLow == 16'h0320 || devLow == 16'h07D0;
  endproperty
  property p_host_low;
    $rose(hostOeN) |-> hostLow inside {16'h03E8, 16'h07D0, 16'h1DB0};
  endproperty
  property p_dev_rate;
    s_dev_start |-> devGap >= 16'h0FA0;
  endproperty
  property p_host_rate;
    $fell(hostOeN) |-> hostGap >= 16'h0FA0;
  endproperty
  property p_dev_cycle;
    $fell(devOeN) && devGap < 16'h1F40 |-> devGap == 16'h0FA0;
  endproperty
  property p_read_delay;
    $fell(devOeN) && devGap >= 16'h1F40 |-> sinceHost >= 16'h0FA0 && sinceHost <= 16'h0FA8;
  endproperty
  property p_recovery;
    s_break_end |-> lineIn;
  endproperty
  property p_recovery_hold;
    recLeft != 10'h000 |-> lineIn;
  endproperty

  a_dev_pull: assert property (p_dev_pull) else $error("device line drive is not a pull low");
  a_host_pull: assert property (p_host_pull) else $error("host line drive is not a pull low");
  a_dev_low: assert property (p_dev_low) else $error("device bit low time wrong");
  a_host_low: assert property (p_host_low) else $error("host bit or break low time wrong");
  a_dev_rate: assert property (p_dev_rate) else $error("device bits too fast");
  a_host_rate: assert property (p_host_rate) else $error("host bits too fast");
  a_dev_cycle: assert property (p_dev_cycle) else $error("device bit cycle wrong");
  a_read_delay: assert property (p_read_delay) else $error("read answer delay wrong");
  a_recovery: assert property (p_recovery) else $error("line low during break recovery");
  a_recovery_hold: assert property (p_recovery_hold) else $error("line low before recovery ends");
endmodule : swg_link_properties

// file: single_wire_gauge_host_port_bench.sv
// Self-checking bench: host port against a device, plus a second device driven by hand.
`timescale 1ns/1ps
module single_wire_gauge_host_port_bench;
  logic clock;
  logic reset_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic userWrEn;
  logic [6:0] userAddr;
  logic [7:0] userData;
  logic shipMode1;
  logic shipArmed1;
  logic unlocked1;
  logic shipMode2;
  logic shipArmed2;
  logic unlocked2;
  logic [6:0] rdAddr;
  logic [7:0] rdData;
  logic [31:0] rnd;
  logic batteryOk;
  int err_total;
  int n_compared;
  int seed;

  swg_link_if link();
  swg_link_if link2();

  // Short ship counts keep the run brief; the glitch filter must stay well under the low count.
  swg_device #(.SHIP_LOW_CYC(3000), .SHIP_GLITCH_CYC(200)) swg_device_inst (.clock(clock), .reset_n(reset_n),
    .link(link), .batteryAbovePor(batteryOk), .userWrEn(userWrEn), .userAddr(userAddr), .userData(userData),
    .shipMode(shipMode1), .shipArmed(shipArmed1), .eepromUnlocked(unlocked1));
  swg_device #(.SHIP_LOW_CYC(3000), .SHIP_GLITCH_CYC(200)) swg_device_inst2 (.clock(clock), .reset_n(reset_n),
    .link(link2), .batteryAbovePor(batteryOk), .userWrEn(userWrEn), .userAddr(userAddr), .userData(userData),
    .shipMode(shipMode2), .shipArmed(shipArmed2), .eepromUnlocked(unlocked2));
  swg_host swg_host_inst (.clock(clock), .reset_n(reset_n), .link(link), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  swg_link_properties swg_link_properties_inst (.clock(clock), .reset_n(reset_n), .devOut(link.devOut),
    .devOeN(link.devOeN), .hostOut(link.hostOut), .hostOeN(link.hostOeN), .lineIn(link.lineIn));

  function automatic logic [7:0] cmdByte(input logic wr, input logic [6:0] a);
    return {wr, a};
  endfunction : cmdByte

  task automatic waitc(input int n);
    repeat (n) @(posedge clock);
  endtask : waitc

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
    chk("response", {31'h00000000, hresp}, 32'h00000000);
  endtask : ahb

  task automatic hostRead;
    logic [31:0] r;
    int i;
    ahb(1'b1, 8'h04, {24'h000000, cmdByte(1'b0, rdAddr)}, r);
    ahb(1'b1, 8'h00, 32'h00000003, r);
    ahb(1'b0, 8'h04, 32'h00000000, r);
    chk("command", r, {24'h000000, cmdByte(1'b0, rdAddr)});
    ahb(1'b1, 8'h0C, 32'hFFFFFFFF, r);
    ahb(1'b0, 8'h0C, 32'h00000000, r);
    chk("unmapped", r, 32'h00000000);
    i = 0;
    do begin
      waitc(4000);
      ahb(1'b0, 8'h08, 32'h00000000, r);
      i++;
    end while (r[0] !== 1'b0 && i < 40);
    chk("status", {16'h0000, r[15:8], 6'h00, r[1:0]}, {16'h0000, rdData, 8'h00});
  endtask : hostRead

  task automatic pull(input int lo, input int hi);
    link2.hostOeN <= 1'b0;
    waitc(lo);
    link2.hostOeN <= 1'b1;
    waitc(hi);
  endtask : pull

  task automatic sendByte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      pull(v[i] ? 1000 : 2000, v[i] ? 3000 : 2000);
    end
  endtask : sendByte

  task automatic shipTest;
    pull(7600, 1200);
    pull(2000, 2000);
    pull(7600, 1200);
    sendByte(cmdByte(1'b1, swg_pkg::CTRL_ADDR));
    sendByte(swg_pkg::SHIP_CMD);
    waitc(4000);
    chk("armed", {31'h00000000, shipArmed2}, 32'h00000001);
    link2.hostOeN <= 1'b0;
    waitc(1500);
    chk("ship early", {31'h00000000, shipMode2}, 32'h00000000);
    link2.hostOeN <= 1'b1;
    waitc(50);
    link2.hostOeN <= 1'b0;
    waitc(1600);
    chk("ship entered", {31'h00000000, shipMode2}, 32'h00000001);
    link2.hostOeN <= 1'b1;
    waitc(10);
    chk("ship left", {31'h00000000, shipMode2}, 32'h00000000);
    chk("arm cleared", {31'h00000000, shipArmed2}, 32'h00000000);
    link2.hostOeN <= 1'b0;
    waitc(3500);
    chk("ship again", {31'h00000000, shipMode2}, 32'h00000000);
    link2.hostOeN <= 1'b1;
  endtask : shipTest

  task automatic summarize;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial begin
    // The ship scenario is the longest path, a little over 96000 cycles.
    #4950000;
    err_total++;
    summarize();
  end

  initial begin
    seed = 45;
    err_total = 0;
    n_compared = 0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h00000000;
    userWrEn = 1'b0;
    batteryOk = 1'b1;
    userAddr = 7'h00;
    userData = 8'h00;
    link2.hostOut = 1'b0;
    link2.hostOeN = 1'b1;
    rnd = $random(seed);
    // The address stays clear of the control, mode, unlock and programmable bytes.
    rdAddr = {1'b0, rnd[5:0]} + 7'h10;
    rdData = rnd[15:8];
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    userWrEn <= 1'b1;
    userAddr <= rdAddr;
    userData <= rdData;
    @(posedge clock);
    userAddr <= swg_pkg::MODE_ADDR;
    userData <= 8'h01;
    @(posedge clock);
    userWrEn <= 1'b0;
    fork
      hostRead();
      shipTest();
    join
    chk("unlocked", {31'h00000000, unlocked1}, 32'h00000000);
    chk("unlocked2", {31'h00000000, unlocked2}, 32'h00000000);
    chk("ship idle", {30'h00000000, shipMode1, shipArmed1}, 32'h00000000);
    summarize();
  end
endmodule : single_wire_gauge_host_port_bench
